// File: hdl/acc_core.v
`timescale 1ns/1ps
`default_nettype none
`include "acc_map.vh"
module acc_core #(
  parameter STARTUP_CYC = (`ACC_STARTUP_US * `ACC_CLK_MHZ),
  parameter FIFO_DEPTH  = 4
) (
  // clock and reset
  input  wire        I_SYS_CLK,
  input  wire        I_RSTN,
  // pins from outside the clock domain
  input  wire        I_START_PIN,
  input  wire        I_RESET_PIN_N,
  // command and register strobes
  input  wire        I_CMD_VALID,
  input  wire [7:0]  I_CMD_CODE,
  input  wire        I_REG_WR,
  input  wire        I_REG_RD,
  input  wire [4:0]  I_REG_ADDR,
  input  wire [7:0]  I_REG_WDATA,
  // filter interface
  input  wire        I_FILT_VALID,
  input  wire [15:0] I_FILT_DATA,
  input  wire        I_CHOP_EN,
  // result byte stream
  input  wire        I_OUT_READY,
  // outputs
  output reg  [7:0]  O_REG_RDATA,
  output reg         O_OUT_VALID,
  output reg  [7:0]  O_OUT_BYTE,
  output reg         O_RESULT_READY_N,
  output reg         O_BRIDGE_SW_CLOSED,
  output reg         O_CONV_RUN,
  output reg         O_FILT_RESTART,
  output reg  [2:0]  O_MONITOR_SELECT,
  output reg         O_INT_OSC_SEL,
  output reg         O_POWERED_DOWN
);
  // ==========================================================
  // pin synchronisers
  reg [1:0] start_sync_reg;
  reg [1:0] rstp_sync_reg;
  reg       start_prev_reg;
  wire      start_s   = start_sync_reg[1];
  wire      start_rise = start_s & ~start_prev_reg;
  wire      pin_rst   = ~rstp_sync_reg[1];

  always @(posedge I_SYS_CLK) begin
    start_sync_reg <= {start_sync_reg[0], I_START_PIN};
    rstp_sync_reg  <= {rstp_sync_reg[0], I_RESET_PIN_N};
    start_prev_reg <= start_s;
  end

  // ==========================================================
  // modes
  localparam [1:0] M_STBY = 2'h0;
  localparam [1:0] M_CONV = 2'h1;
  localparam [1:0] M_CAL  = 2'h2;
  localparam [1:0] M_DOWN = 2'h3;
  localparam [1:0] C_SELF = 2'h0;
  localparam [1:0] C_SOFF = 2'h1;
  localparam [1:0] C_GAIN = 2'h2;

  wire cmd_sleep = I_CMD_VALID & (I_CMD_CODE == `ACC_CMD_SLEEP);
  wire cmd_wake  = I_CMD_VALID & (I_CMD_CODE == `ACC_CMD_WAKE);
  wire cmd_reset = I_CMD_VALID & (I_CMD_CODE == `ACC_CMD_RESET);
  wire cmd_start = I_CMD_VALID & (I_CMD_CODE == `ACC_CMD_START);
  wire cmd_stop  = I_CMD_VALID & (I_CMD_CODE == `ACC_CMD_STOP);
  wire cmd_sfo   = I_CMD_VALID & (I_CMD_CODE == `ACC_CMD_SELF_OFFSET_CAL_CMD);
  wire cmd_syo   = I_CMD_VALID & (I_CMD_CODE == `ACC_CMD_SYS_OFFSET_CAL_CMD);
  wire cmd_syg   = I_CMD_VALID & (I_CMD_CODE == `ACC_CMD_SYS_GAIN_CAL_CMD);
  // a reset command is ignored in power-down until wake
  wire soft_rst  = pin_rst | (cmd_reset & (O_POWERED_DOWN == 1'b0));

  reg  [1:0]  mode_reg;
  reg  [1:0]  cal_kind_reg;
  reg  [4:0]  cal_cnt_reg;
  reg  [21:0] cal_acc_reg;
  reg  [7:0]  exc1_reg;
  reg  [7:0]  sys_reg;
  reg  [15:0] ofc_reg;
  reg  [15:0] gain_reg;
  reg         por_flag_reg;
  reg         rdy_n_reg;
  reg  [31:0] boot_cnt_reg;
  reg         boot_done_reg;
  reg         por_pend_reg;
  wire        boot_hit = ~boot_done_reg & (boot_cnt_reg == STARTUP_CYC - 1);

  wire [1:0] avg_sel = sys_reg[`ACC_SYS_AVG_HI:`ACC_SYS_AVG_LO];
  reg  [4:0] avg_n;
  reg  [2:0] avg_sh;
  always @* begin
    case (avg_sel)
      2'h0:    begin avg_n = 5'h01; avg_sh = 3'h0; end
      2'h1:    begin avg_n = 5'h04; avg_sh = 3'h2; end
      2'h2:    begin avg_n = 5'h08; avg_sh = 3'h3; end
      default: begin avg_n = 5'h10; avg_sh = 3'h4; end
    endcase
  end

  wire        in_stby   = (mode_reg == M_STBY) | ~start_s;
  wire        cal_req   = (cmd_sfo | cmd_syo | cmd_syg) & ~in_stby;
  wire        conv_mode = (mode_reg == M_CONV) | (mode_reg == M_CAL);
  wire [21:0] ext_samp  = {{6{I_FILT_DATA[15]}}, I_FILT_DATA};
  wire [21:0] cal_sum   = cal_acc_reg + ext_samp;
  wire [21:0] cal_avg   = $signed(cal_sum) >>> avg_sh;
  wire        cal_last  = I_FILT_VALID & (mode_reg == M_CAL) &
                          (cal_cnt_reg == avg_n - 5'h01);
  // gain calibration: 4000h * 7FFFh / measured, guarded against zero
  wire [15:0] meas_adj  = cal_avg[15:0] - (I_CHOP_EN ? 16'h0000 : ofc_reg);
  wire [15:0] meas_pos  = meas_adj[15] ? 16'h0001 :
                          ((meas_adj == 16'h0000) ? 16'h0001 : meas_adj);
  wire [30:0] gain_num  = {16'h7FFF, 15'h0000} >> 1;
  wire [30:0] gain_div  = gain_num / {15'h0000, meas_pos};
  wire [15:0] cal_gain_q = (gain_div[30:16] != 15'h0000) ? 16'hFFFF :
                           gain_div[15:0];

  // ==========================================================
  // mode machine, registers and calibration
  always @(posedge I_SYS_CLK) begin
    O_FILT_RESTART <= 1'b0;
    if (!I_RSTN) begin
      mode_reg      <= M_STBY;
      cal_kind_reg  <= C_SELF;
      cal_cnt_reg   <= 5'h00;
      cal_acc_reg   <= 22'h000000;
      exc1_reg      <= `ACC_EXC1_RST;
      sys_reg       <= `ACC_SYS_RST;
      ofc_reg       <= `ACC_OFC_RST;
      gain_reg      <= `ACC_GAIN_UNITY;
      por_flag_reg  <= 1'b0;
      por_pend_reg  <= 1'b1;
      rdy_n_reg     <= 1'b1;
      boot_cnt_reg  <= 32'h00000000;
      boot_done_reg <= 1'b0;
      O_MONITOR_SELECT <= `ACC_MON_OFF;
      O_INT_OSC_SEL    <= 1'b1;
      O_POWERED_DOWN   <= 1'b0;
    end else if (soft_rst) begin
      mode_reg      <= M_STBY;
      exc1_reg      <= `ACC_EXC1_RST;
      sys_reg       <= `ACC_SYS_RST;
      ofc_reg       <= `ACC_OFC_RST;
      gain_reg      <= `ACC_GAIN_UNITY;
      cal_cnt_reg   <= 5'h00;
      cal_acc_reg   <= 22'h000000;
      rdy_n_reg     <= 1'b1;
      boot_cnt_reg  <= 32'h00000000;
      boot_done_reg <= 1'b0;
      O_MONITOR_SELECT <= `ACC_MON_OFF;
      O_INT_OSC_SEL    <= 1'b1;
      O_POWERED_DOWN   <= 1'b0;
    end else begin
      // start-up configuration timer
      if (!boot_done_reg) begin
        if (boot_hit) begin
          boot_done_reg <= 1'b1;
          rdy_n_reg     <= 1'b0;
          por_pend_reg  <= 1'b0;
          // a pin or command reset does not raise the flag again
          if (por_pend_reg) por_flag_reg <= 1'b1;
        end else begin
          boot_cnt_reg <= boot_cnt_reg + 32'h00000001;
        end
      end
      // registers are frozen in power-down until wake
      if (I_REG_WR && !O_POWERED_DOWN) begin
        case (I_REG_ADDR)
          `ACC_REG_STATUS:
            // the start-up timer's set wins over a clear in that cycle
            if (!I_REG_WDATA[`ACC_ST_POR_BIT] && !boot_hit)
              por_flag_reg <= 1'b0;
          `ACC_REG_EXC1:    exc1_reg <= I_REG_WDATA;
          `ACC_REG_SYS:     sys_reg  <= I_REG_WDATA;
          `ACC_REG_OFC_LO:  ofc_reg[7:0]   <= I_REG_WDATA;
          `ACC_REG_OFC_HI:  ofc_reg[15:8]  <= I_REG_WDATA;
          `ACC_REG_GAIN_LO: gain_reg[7:0]  <= I_REG_WDATA;
          `ACC_REG_GAIN_HI: gain_reg[15:8] <= I_REG_WDATA;
          default: ;
        endcase
      end
      if (cmd_sleep) begin
        mode_reg       <= M_DOWN;
        O_POWERED_DOWN <= 1'b1;
        exc1_reg[`ACC_EXC1_SW_BIT] <= 1'b0;
        O_MONITOR_SELECT <= `ACC_MON_OFF;
      end else begin
        case (mode_reg)
          M_DOWN: if (cmd_wake) begin
            mode_reg       <= M_STBY;
            O_POWERED_DOWN <= 1'b0;
          end
          M_STBY: if (start_rise | cmd_start) begin
            mode_reg       <= M_CONV;
            O_FILT_RESTART <= 1'b1;
          end
          M_CONV: begin
            if (start_rise | cmd_start) begin
              O_FILT_RESTART <= 1'b1;
            end else if (cmd_stop) begin
              mode_reg <= M_STBY;
            end else if (cal_req) begin
              mode_reg       <= M_CAL;
              O_FILT_RESTART <= 1'b1;
              cal_cnt_reg    <= 5'h00;
              cal_acc_reg    <= 22'h000000;
              cal_kind_reg   <= cmd_sfo ? C_SELF : (cmd_syo ? C_SOFF : C_GAIN);
              if (cmd_sfo) O_MONITOR_SELECT <= `ACC_MON_MID;
            end
          end
          M_CAL: begin
            if (start_rise | cmd_start) begin
              mode_reg       <= M_CONV;
              O_FILT_RESTART <= 1'b1;
              O_MONITOR_SELECT <= `ACC_MON_OFF;
            end else if (I_FILT_VALID) begin
              cal_acc_reg <= cal_sum;
              cal_cnt_reg <= cal_cnt_reg + 5'h01;
              if (cal_last) begin
                if (cal_kind_reg == C_GAIN) begin
                  // gain word scales the measured full scale to 7FFFh
                  gain_reg <= cal_gain_q;
                end else begin
                  ofc_reg <= cal_avg[15:0];
                end
                mode_reg         <= M_CONV;
                O_FILT_RESTART   <= 1'b1;
                O_MONITOR_SELECT <= `ACC_MON_OFF;
              end
            end
          end
          default: mode_reg <= M_STBY;
        endcase
      end
    end
  end

  // ==========================================================
  // correction datapath
  wire [15:0] ofs_use  = I_CHOP_EN ? 16'h0000 : ofc_reg;
  wire [16:0] diff     = {I_FILT_DATA[15], I_FILT_DATA} -
                         {ofs_use[15], ofs_use};
  wire signed [33:0] prod = $signed(diff) * $signed({1'b0, gain_reg});
  wire signed [33:0] scal = prod >>> 14;
  wire [15:0] corr = (scal > 34'sh0_0000_7FFF) ? 16'h7FFF :
                     (scal < -34'sh0_0000_8000) ? 16'h8000 :
                     scal[15:0];

  // ==========================================================
  // result framing into the byte FIFO
  localparam [1:0] F_IDLE = 2'h0;
  localparam [1:0] F_SEND = 2'h1;
  reg  [1:0]  fr_state_reg;
  reg  [31:0] fr_bytes_reg;
  reg  [2:0]  fr_left_reg;
  wire [7:0]  status_byte = {por_flag_reg, rdy_n_reg, 6'h00};
  wire        emit = I_FILT_VALID & (mode_reg == M_CONV) & ~cmd_sleep;
  wire        f_in_ready;
  wire        f_out_valid;
  wire [7:0]  f_out_data;
  wire        f_push = (fr_state_reg == F_SEND);

  // CRC over up to three bytes, MSB first, zero seed, no inversion
  function [7:0] crc8;
    input [23:0] d;
    input        three;
    integer      k;
    reg [7:0]    r;
    begin
      r = 8'h00;
      for (k = 23; k >= 0; k = k - 1) begin
        if (k < 16 || three) begin
          r = {r[6:0], 1'b0} ^ ((r[7] ^ d[k]) ? `ACC_CRC_POLY : 8'h00);
        end
      end
      crc8 = r;
    end
  endfunction

  wire        stat_on = sys_reg[`ACC_SYS_STAT_BIT];
  wire        crc_on  = sys_reg[`ACC_SYS_CRC_BIT];
  wire [23:0] crc_in  = stat_on ? {status_byte, corr} : {corr, 8'h00};
  wire [7:0]  crc_v   = stat_on ? crc8(crc_in, 1'b1)
                                : crc8({8'h00, corr}, 1'b0);

  always @(posedge I_SYS_CLK) begin
    if (!I_RSTN || soft_rst || cmd_sleep) begin
      fr_state_reg <= F_IDLE;
      fr_bytes_reg <= 32'h00000000;
      fr_left_reg  <= 3'h0;
      O_RESULT_READY_N <= 1'b1;
    end else begin
      if (I_REG_RD) O_RESULT_READY_N <= 1'b1;
      case (fr_state_reg)
        F_IDLE: if (emit) begin
          O_RESULT_READY_N <= 1'b0;
          fr_state_reg <= F_SEND;
          if (stat_on) begin
            fr_bytes_reg <= {status_byte, corr, crc_v};
          end else begin
            fr_bytes_reg <= {corr, crc_v, 8'h00};
          end
          fr_left_reg <= 3'h2 + {2'h0, stat_on} + {2'h0, crc_on};
        end
        F_SEND: if (f_in_ready) begin
          fr_bytes_reg <= {fr_bytes_reg[23:0], 8'h00};
          fr_left_reg  <= fr_left_reg - 3'h1;
          if (fr_left_reg == 3'h1) fr_state_reg <= F_IDLE;
        end
        default: fr_state_reg <= F_IDLE;
      endcase
    end
  end

  acc_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH), .AW(2)) u_fifo (
    .clk       (I_SYS_CLK),
    .rst_n     (I_RSTN),
    .in_valid  (f_push),
    .in_ready  (f_in_ready),
    .in_data   (fr_bytes_reg[31:24]),
    .out_valid (f_out_valid),
    .out_ready (I_OUT_READY | ~O_OUT_VALID),
    .out_data  (f_out_data)
  );

  // ==========================================================
  // registered outputs
  always @(posedge I_SYS_CLK) begin
    if (!I_RSTN) begin
      O_OUT_VALID        <= 1'b0;
      O_OUT_BYTE         <= 8'h00;
      O_REG_RDATA        <= 8'h00;
      O_BRIDGE_SW_CLOSED <= 1'b0;
      O_CONV_RUN         <= 1'b0;
    end else begin
      if (I_OUT_READY | ~O_OUT_VALID) begin
        O_OUT_VALID <= f_out_valid;
        O_OUT_BYTE  <= f_out_data;
      end
      O_BRIDGE_SW_CLOSED <= exc1_reg[`ACC_EXC1_SW_BIT] & ~cmd_sleep;
      O_CONV_RUN         <= conv_mode & ~cmd_sleep;
      case (I_REG_ADDR)
        `ACC_REG_STATUS:  O_REG_RDATA <= status_byte;
        `ACC_REG_EXC1:    O_REG_RDATA <= exc1_reg;
        `ACC_REG_SYS:     O_REG_RDATA <= sys_reg;
        `ACC_REG_OFC_LO:  O_REG_RDATA <= ofc_reg[7:0];
        `ACC_REG_OFC_HI:  O_REG_RDATA <= ofc_reg[15:8];
        `ACC_REG_GAIN_LO: O_REG_RDATA <= gain_reg[7:0];
        `ACC_REG_GAIN_HI: O_REG_RDATA <= gain_reg[15:8];
        default:          O_REG_RDATA <= 8'h00;
      endcase
    end
  end
endmodule // acc_core
`default_nettype wire

// File: hdl/acc_fifo.v
`timescale 1ns/1ps
`default_nettype none
module acc_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 4,
  parameter AW    = 2
) (
  input  wire             clk,
  input  wire             rst_n,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wp_reg;
  reg [AW-1:0]    rp_reg;
  reg [AW:0]      cnt_reg;
  wire            push;
  wire            pop;

  assign in_ready  = (cnt_reg != DEPTH[AW:0]);
  assign out_valid = (cnt_reg != {(AW+1){1'b0}});
  assign out_data  = mem[rp_reg];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always @(posedge clk) begin
    if (push) begin
      mem[wp_reg] <= in_data;
    end
    if (!rst_n) begin
      wp_reg  <= {AW{1'b0}};
      rp_reg  <= {AW{1'b0}};
      cnt_reg <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wp_reg <= (wp_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp_reg + 1'b1;
      end
      if (pop) begin
        rp_reg <= (rp_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp_reg + 1'b1;
      end
      cnt_reg <= cnt_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule // acc_fifo
`default_nettype wire

// File: hdl/acc_map.vh
`ifndef ACC_MAP_VH
`define ACC_MAP_VH
// command codes seen on the command strobe
`define ACC_CMD_WAKE      8'h02
`define ACC_CMD_SLEEP     8'h04
`define ACC_CMD_RESET     8'h06
`define ACC_CMD_START     8'h08
`define ACC_CMD_STOP      8'h0A
`define ACC_CMD_SELF_OFFSET_CAL_CMD    8'h19
`define ACC_CMD_SYS_OFFSET_CAL_CMD    8'h16
`define ACC_CMD_SYS_GAIN_CAL_CMD    8'h17
// configuration register indices
`define ACC_REG_STATUS    5'h01
`define ACC_REG_EXC1      5'h06
`define ACC_REG_SYS       5'h09
`define ACC_REG_OFC_LO    5'h0A
`define ACC_REG_OFC_HI    5'h0B
`define ACC_REG_GAIN_LO   5'h0C
`define ACC_REG_GAIN_HI   5'h0D
// field positions
`define ACC_EXC1_SW_BIT   7
`define ACC_SYS_CRC_BIT   1
`define ACC_SYS_STAT_BIT  0
`define ACC_SYS_AVG_HI    4
`define ACC_SYS_AVG_LO    3
`define ACC_SYS_CHOP_BIT  2
`define ACC_ST_POR_BIT    7
`define ACC_ST_RDY_BIT    6
// reset values and monitor select codes
`define ACC_SYS_RST       8'h10
`define ACC_EXC1_RST      8'h00
`define ACC_GAIN_UNITY    16'h4000
`define ACC_OFC_RST       16'h0000
`define ACC_MON_MID       3'h1
`define ACC_MON_OFF       3'h0
// checksum polynomial, low eight coefficients
`define ACC_CRC_POLY      8'h07
// start-up configuration time in microseconds, and system clock in MHz
`define ACC_STARTUP_US    2200
`define ACC_CLK_MHZ       200
`endif

// File: testbench/acc_core_checker.sv
`timescale 1ns/1ps
`default_nettype none
`include "acc_map.vh"
module acc_core_checker (
  // control inputs
  input wire logic       I_SYS_CLK,
  input wire logic       I_RSTN,
  input wire logic       I_RESET_PIN_N,
  input wire logic       I_CMD_VALID,
  input wire logic [7:0] I_CMD_CODE,
  input wire logic       I_REG_WR,
  input wire logic       I_REG_RD,
  input wire logic [4:0] I_REG_ADDR,
  input wire logic [7:0] I_REG_WDATA,
  input wire logic       I_FILT_VALID,
  input wire logic       I_OUT_READY,
  // watched outputs
  input wire logic       O_OUT_VALID,
  input wire logic [7:0] O_OUT_BYTE,
  input wire logic       O_RESULT_READY_N,
  input wire logic       O_BRIDGE_SW_CLOSED,
  input wire logic       O_CONV_RUN,
  input wire logic       O_FILT_RESTART,
  input wire logic [2:0] O_MONITOR_SELECT,
  input wire logic       O_INT_OSC_SEL,
  input wire logic       O_POWERED_DOWN
);
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_RSTN);
  // ==========
  // sequences
  sequence sleep_s;
    I_CMD_VALID && I_CMD_CODE == `ACC_CMD_SLEEP;
  endsequence
  sequence sw_wr_s;
    I_REG_WR && I_REG_ADDR == `ACC_REG_EXC1 && !O_POWERED_DOWN &&
      !I_CMD_VALID;
  endsequence
  sequence stall_s;
    O_OUT_VALID && !I_OUT_READY;
  endsequence
  // ==========
  // properties
  sw_close_a: assert property (sw_wr_s ##0 I_REG_WDATA[7] |->
    ##[1:2] O_BRIDGE_SW_CLOSED) else $error("switch did not close");
  sw_open_a: assert property (sw_wr_s ##0 !I_REG_WDATA[7] |->
    ##[1:2] !O_BRIDGE_SW_CLOSED) else $error("switch did not open");
  sleep_off_a: assert property (sleep_s |->
    ##[1:2] (O_POWERED_DOWN && !O_CONV_RUN)) else $error("sleep not taken");
  pd_quiet_a: assert property (O_POWERED_DOWN |->
    !O_CONV_RUN && !O_BRIDGE_SW_CLOSED) else $error("activity in power-down");
  byte_hold_a: assert property (stall_s |=>
    O_OUT_VALID && $stable(O_OUT_BYTE))
    else $error("byte dropped under stall");
  mon_sel_a: assert property (O_MONITOR_SELECT != `ACC_MON_OFF |->
    O_MONITOR_SELECT == `ACC_MON_MID && O_CONV_RUN)
    else $error("bad monitor code");
  // a restart pulse marks a start taken one cycle before the run flag shows it
  standby_cal_a: assert property (I_CMD_VALID &&
    I_CMD_CODE == `ACC_CMD_SELF_OFFSET_CAL_CMD && !O_CONV_RUN && !O_FILT_RESTART |->
    ##[1:2] O_MONITOR_SELECT == `ACC_MON_OFF) else $error("cal in standby");
  start_kick_a: assert property (I_CMD_VALID &&
    I_CMD_CODE == `ACC_CMD_START && !O_POWERED_DOWN |->
    ##[1:3] O_FILT_RESTART) else $error("no restart");
  ready_fall_a: assert property ($fell(O_RESULT_READY_N) |->
    $past(I_FILT_VALID)) else $error("ready without result");
  read_rise_a: assert property (I_REG_RD && !I_FILT_VALID |=>
    O_RESULT_READY_N) else $error("ready not raised");
  pin_reset_a: assert property (!I_RESET_PIN_N [*3] |-> ##[1:3]
    (O_INT_OSC_SEL && !O_BRIDGE_SW_CLOSED && !O_CONV_RUN))
    else $error("pin reset");
endmodule // acc_core_checker

bind acc_core acc_core_checker i_acc_core_checker (
  .I_SYS_CLK(I_SYS_CLK), .I_RSTN(I_RSTN), .I_RESET_PIN_N(I_RESET_PIN_N),
  .I_CMD_VALID(I_CMD_VALID), .I_CMD_CODE(I_CMD_CODE), .I_REG_WR(I_REG_WR),
  .I_REG_RD(I_REG_RD), .I_REG_ADDR(I_REG_ADDR), .I_REG_WDATA(I_REG_WDATA),
  .I_FILT_VALID(I_FILT_VALID), .I_OUT_READY(I_OUT_READY),
  .O_OUT_VALID(O_OUT_VALID), .O_OUT_BYTE(O_OUT_BYTE),
  .O_RESULT_READY_N(O_RESULT_READY_N),
  .O_BRIDGE_SW_CLOSED(O_BRIDGE_SW_CLOSED),
  .O_CONV_RUN(O_CONV_RUN), .O_FILT_RESTART(O_FILT_RESTART),
  .O_MONITOR_SELECT(O_MONITOR_SELECT), .O_INT_OSC_SEL(O_INT_OSC_SEL),
  .O_POWERED_DOWN(O_POWERED_DOWN));
`default_nettype wire

// File: testbench/acc_core_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "acc_map.vh"
module acc_core_tb;
  // ==========
  // signals
  logic        sys_clk = 1'b0, rstn = 1'b0, start_pin = 1'b0;
  logic        reset_pin_n = 1'b1, cmd_valid = 1'b0, reg_wr = 1'b0;
  logic        reg_rd = 1'b0, filt_valid = 1'b0, chop_en = 1'b0, stall = 1'b0;
  logic [7:0]  cmd_code = 8'h00, reg_wdata = 8'h00, reg_rdata, out_byte;
  logic [4:0]  reg_addr = 5'h00;
  logic [15:0] filt_data = 16'h0000, ov, gv, cv, iv, xv;
  logic        out_ready, out_valid, ready_n, sw_closed, conv_run;
  logic        filt_restart, int_osc, pd, seen;
  logic [2:0]  mon_sel;
  logic [7:0]  exq [$];
  int          err_count = 0, checks_done = 0, cyc = 0;
  // offset, gain, chop, input, expected result
  logic [79:0] tv [8] = '{80'h0010_4000_0000_0100_00F0,
    80'hFFFF_4000_0000_0100_0101, 80'hFFFF_4000_0001_0100_0100,
    80'h8000_4000_0000_8000_0000, 80'h0000_8000_0000_0100_0200,
    80'h0000_8000_0000_7000_7FFF, 80'h0000_8000_0000_9000_8000,
    80'h0000_4000_0000_8000_8000};

  always #2.5 sys_clk = ~sys_clk;

  acc_core #(.STARTUP_CYC(20)) i_acc_core (
    .I_SYS_CLK(sys_clk), .I_RSTN(rstn), .I_START_PIN(start_pin),
    .I_RESET_PIN_N(reset_pin_n), .I_CMD_VALID(cmd_valid),
    .I_CMD_CODE(cmd_code), .I_REG_WR(reg_wr), .I_REG_RD(reg_rd),
    .I_REG_ADDR(reg_addr), .I_REG_WDATA(reg_wdata),
    .I_FILT_VALID(filt_valid), .I_FILT_DATA(filt_data), .I_CHOP_EN(chop_en),
    .I_OUT_READY(out_ready), .O_REG_RDATA(reg_rdata),
    .O_OUT_VALID(out_valid), .O_OUT_BYTE(out_byte),
    .O_RESULT_READY_N(ready_n), .O_BRIDGE_SW_CLOSED(sw_closed),
    .O_CONV_RUN(conv_run), .O_FILT_RESTART(filt_restart),
    .O_MONITOR_SELECT(mon_sel), .O_INT_OSC_SEL(int_osc),
    .O_POWERED_DOWN(pd));

  acc_host i_acc_host (.clk(sys_clk), .valid(out_valid), .data(out_byte),
    .stall(stall), .ready(out_ready));

  // ==========
  // access tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] exp);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(posedge sys_clk);
    #1 chk(reg_rdata, exp);
    @(posedge sys_clk);
  endtask
  task automatic cmd(input logic [7:0] c);
    cmd_valid <= 1'b1;
    cmd_code <= c;
    @(posedge sys_clk);
    cmd_valid <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask
  task automatic fo(input logic [15:0] v);
    filt_valid <= 1'b1;
    filt_data <= v;
    @(posedge sys_clk);
    filt_valid <= 1'b0;
    @(posedge sys_clk);
  endtask
  // m is {checksum, status} as in the system register
  task automatic add(input logic [15:0] r, input logic [1:0] m);
    logic [23:0] d;
    d = {m[0] ? 8'h80 : 8'h00, r};
    if (m[0])
      exq.push_back(8'h80);
    exq.push_back(r[15:8]);
    exq.push_back(r[7:0]);
    if (m[1])
      exq.push_back(i_acc_host.crc8(d, m[0] ? 24 : 16));
  endtask
  task automatic drain;
    int k;
    k = 0;
    while (i_acc_host.got.size() < exq.size() && k < 300) begin
      @(posedge sys_clk);
      k++;
    end
    repeat (4) @(posedge sys_clk);
    chk(16'(i_acc_host.got.size()), 16'(exq.size()));
    foreach (exq[i]) chk(i_acc_host.got[i], exq[i]);
    i_acc_host.got.delete();
    exq.delete();
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 6000) begin
      err_count++;
      end_sim();
    end
  end

  // ==========
  // main sequence
  initial begin
    repeat (3) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (30) @(posedge sys_clk);
    rd(`ACC_REG_STATUS, 8'h80);
    rd(`ACC_REG_SYS, `ACC_SYS_RST);
    rd(`ACC_REG_GAIN_HI, 8'h40);
    rd(`ACC_REG_OFC_LO, 8'h00);
    chk({int_osc, sw_closed}, 2'b10);
    wr(`ACC_REG_EXC1, 8'h80);
    chk(sw_closed, 1'b1);
    wr(`ACC_REG_EXC1, 8'h00);
    chk(sw_closed, 1'b0);
    wr(`ACC_REG_EXC1, 8'h80);
    cmd(`ACC_CMD_SLEEP);
    chk({sw_closed, pd}, 2'b01);
    cmd(`ACC_CMD_WAKE);
    cmd(`ACC_CMD_START);
    chk({pd, conv_run}, 2'b01);
    wr(`ACC_REG_SYS, 8'h12);
    fo(16'h1234);
    add(16'h1234, 2'b10);
    drain;
    chk(ready_n, 1'b0);
    rd(`ACC_REG_STATUS, 8'h80);
    chk(ready_n, 1'b1);
    // two frames while the host stalls overfill the four-word buffer
    wr(`ACC_REG_SYS, 8'h13);
    stall <= 1'b1;
    fo(16'h8001);
    repeat (6) @(posedge sys_clk);
    fo(16'h00FF);
    add(16'h8001, 2'b11);
    add(16'h00FF, 2'b11);
    repeat (20) @(posedge sys_clk);
    chk(out_valid, 1'b1);
    stall <= 1'b0;
    drain;
    wr(`ACC_REG_SYS, 8'h10);
    for (int i = 0; i < 8; i++) begin
      {ov, gv, cv, iv, xv} = tv[i];
      wr(`ACC_REG_OFC_LO, ov[7:0]);
      wr(`ACC_REG_OFC_HI, ov[15:8]);
      wr(`ACC_REG_GAIN_LO, gv[7:0]);
      wr(`ACC_REG_GAIN_HI, gv[15:8]);
      chop_en <= cv[0];
      fo(iv);
      add(xv, 2'b00);
      drain;
    end
    cmd(`ACC_CMD_STOP);
    cmd(`ACC_CMD_SELF_OFFSET_CAL_CMD);
    chk(mon_sel, `ACC_MON_OFF);
    rd(`ACC_REG_OFC_LO, 8'h00);
    start_pin <= 1'b1;
    seen = 1'b0;
    repeat (8) begin
      @(posedge sys_clk);
      seen = seen | filt_restart;
    end
    chk({seen, conv_run}, 2'b11);
    wr(`ACC_REG_SYS, 8'h00);
    cmd(`ACC_CMD_SELF_OFFSET_CAL_CMD);
    chk(mon_sel, `ACC_MON_MID);
    fo(16'h0005);
    repeat (4) @(posedge sys_clk);
    chk(mon_sel, `ACC_MON_OFF);
    rd(`ACC_REG_OFC_LO, 8'h05);
    fo(16'h0105);
    add(16'h0100, 2'b00);
    drain;
    wr(`ACC_REG_SYS, 8'h08);
    cmd(`ACC_CMD_SYS_OFFSET_CAL_CMD);
    for (int i = 1; i < 5; i++)
      fo(16'(4 * i));
    repeat (4) @(posedge sys_clk);
    rd(`ACC_REG_OFC_LO, 8'h0A);
    // the upper gain byte is 7Fh whether or not the offset is removed first
    wr(`ACC_REG_SYS, 8'h18);
    cmd(`ACC_CMD_SYS_GAIN_CAL_CMD);
    repeat (16) fo(16'h400A);
    repeat (4) @(posedge sys_clk);
    rd(`ACC_REG_GAIN_HI, 8'h7F);
    i_acc_host.got.delete();
    cmd(`ACC_CMD_SLEEP);
    chk({conv_run, pd, sw_closed}, 3'b010);
    cmd(`ACC_CMD_WAKE);
    wr(`ACC_REG_EXC1, 8'h80);
    reset_pin_n <= 1'b0;
    repeat (6) @(posedge sys_clk);
    reset_pin_n <= 1'b1;
    repeat (40) @(posedge sys_clk);
    rd(`ACC_REG_EXC1, `ACC_EXC1_RST);
    rd(`ACC_REG_GAIN_HI, 8'h40);
    rd(`ACC_REG_STATUS, 8'h80);
    chk({int_osc, conv_run, sw_closed}, 3'b100);
    // the flag clears by writing zero and a command reset must not raise it
    wr(`ACC_REG_STATUS, 8'h00);
    rd(`ACC_REG_STATUS, 8'h00);
    wr(`ACC_REG_EXC1, 8'h80);
    cmd(`ACC_CMD_RESET);
    repeat (30) @(posedge sys_clk);
    rd(`ACC_REG_EXC1, `ACC_EXC1_RST);
    rd(`ACC_REG_STATUS, 8'h00);
    chk({int_osc, sw_closed}, 2'b10);
    end_sim();
  end
endmodule // acc_core_tb
`default_nettype wire

// File: testbench/acc_host.sv
`timescale 1ns/1ps
`default_nettype none
module acc_host (
  // byte stream from the device
  input  wire logic       clk,
  input  wire logic       valid,
  input  wire logic [7:0] data,
  input  wire logic       stall,
  output logic            ready
);
  logic [7:0] got [$];
  initial ready = 1'b0;
  // checksum: msb first, zero seed, no inversion, x^8+x^2+x+1
  function automatic logic [7:0] crc8(input logic [23:0] d, input int n);
    logic [7:0] r;
    r = 8'h00;
    for (int i = n - 1; i >= 0; i--)
      r = {r[6:0], 1'b0} ^ ((r[7] ^ d[i]) ? 8'h07 : 8'h00);
    return r;
  endfunction
  // a slow host simply holds ready low while stalled
  always @(posedge clk) begin
    if (valid && ready)
      got.push_back(data);
    ready <= !stall;
  end
endmodule // acc_host
`default_nettype wire
